// File: hdl/dsf_consts.svh
// register offsets, field positions, reset values and timing counts
// assumes byte-wide register access through the serial host port
`ifndef DSF_CONSTS_SVH
`define DSF_CONSTS_SVH

`define DSF_ADDR_W        8
`define DSF_BYTE_W        8
`define DSF_FIELD_W       16
`define DSF_NUM_BYTES     12

`define DSF_OFS_REF3_LIM  8'h4e
`define DSF_OFS_PLL_CFG   8'h4f
`define DSF_OFS_A_BASE    8'h50
`define DSF_OFS_A_MULT    8'h52
`define DSF_OFS_A_RATIO   8'h54
`define DSF_OFS_B_BASE    8'h58
`define DSF_OFS_LAST      8'h59

`define DSF_RST_REF3_LIM  8'h55
`define DSF_RST_PLL_CFG   8'hf2
`define DSF_RST_A_BASE    16'h9c40
`define DSF_RST_A_MULT    16'h0798
`define DSF_RST_A_RATIO   32'h00010001
`define DSF_RST_B_BASE    16'h61a8

`define DSF_PLL_SEL_LSB   0
`define DSF_PLL_SEL_MSB   1
`define DSF_PHASE_EN_LSB  4
`define DSF_PHASE_EN_MSB  7

`define DSF_SCALE_SHIFT   4
`define DSF_PROD_W        52
`define DSF_DIV_STEPS     52

`endif

// File: hdl/dsf_pkg.sv
// types shared by the configuration bank and its frequency calculator
// assumes dsf_consts.svh is on the include path
`include "dsf_consts.svh"

package dsf_pkg;

  typedef enum logic [1:0]
  {
    DSF_PLL_NONE  = 2'h0,
    DSF_PLL_FIRST = 2'h1,
    DSF_PLL_BOTH  = 2'h2,
    DSF_PLL_RSVD  = 2'h3
  } dsf_pll_sel_t;

  typedef enum logic [2:0]
  {
    DSF_DIV_IDLE = 3'h1,
    DSF_DIV_RUN  = 3'h2,
    DSF_DIV_DONE = 3'h4
  } dsf_div_state_t;

  typedef struct packed
  {
    logic [`DSF_FIELD_W-1:0] base_frequency_value;
    logic [`DSF_FIELD_W-1:0] frequency_multiple_value;
    logic [`DSF_FIELD_W-1:0] fec_numerator;
    logic [`DSF_FIELD_W-1:0] fec_denominator;
  } dsf_synth_cfg_t;

endpackage

// File: hdl/dsf_freq_calc.sv
// synthesizer frequency calculator: base x multiple x 16 x num / den
// assumes a one-cycle start pulse; one quotient bit per clock
`timescale 1ns/1ps
`include "dsf_consts.svh"

module dsf_freq_calc
#(
  parameter int PROD_W = `DSF_PROD_W
)
(
  input  wire logic                  mclk_i,   // 20 MHz clock
  input  wire logic                  rst_i,    // async reset, high
  input  wire logic                  start_i,  // recompute pulse
  input  wire dsf_pkg::dsf_synth_cfg_t cfg_i,  // synthesizer fields
  output logic [PROD_W-1:0]          freq_o,   // frequency in Hz
  output logic                       valid_o,  // freq_o is current
  output logic                       div_err_o // denominator was zero
);
  import dsf_pkg::*;

  localparam int REM_W = `DSF_FIELD_W + 1;
  localparam int CNT_W = $clog2(`DSF_DIV_STEPS);

  dsf_div_state_t          state;
  logic [PROD_W-1:0]       dividend;
  logic [PROD_W-1:0]       quot;
  logic [REM_W-1:0]        rem;
  logic [`DSF_FIELD_W-1:0] den;
  logic [CNT_W-1:0]        cnt;
  logic [PROD_W-1:0]       next_dividend;
  logic [REM_W-1:0]        next_rem;
  logic [REM_W-1:0]        shifted;
  logic                    next_bit;

  // shift-subtract step, restoring division
  always_comb
  begin
    shifted       = {rem[REM_W-2:0], dividend[PROD_W-1]};
    next_bit      = (shifted >= {1'b0, den});
    next_rem      = next_bit ? shifted - {1'b0, den} : shifted;
    next_dividend = {dividend[PROD_W-2:0], 1'b0};
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state     <= DSF_DIV_IDLE;
      dividend  <= '0;
      quot      <= '0;
      rem       <= '0;
      den       <= '0;
      cnt       <= '0;
      freq_o    <= '0;
      valid_o   <= 1'b0;
      div_err_o <= 1'b0;
    end
    else
    begin
      case (state)
        DSF_DIV_IDLE:
        begin
          if (start_i)
          begin
            // product before the ratio carries the fixed factor 16
            dividend <= PROD_W'((PROD_W'(cfg_i.base_frequency_value)
                        * PROD_W'(cfg_i.frequency_multiple_value)
                        * PROD_W'(cfg_i.fec_numerator)) << `DSF_SCALE_SHIFT);
            den      <= cfg_i.fec_denominator;
            rem      <= '0;
            quot     <= '0;
            cnt      <= CNT_W'(`DSF_DIV_STEPS - 1);
            valid_o  <= 1'b0;
            state    <= DSF_DIV_RUN;
          end
        end
        DSF_DIV_RUN:
        begin
          dividend <= next_dividend;
          rem      <= next_rem;
          quot     <= {quot[PROD_W-2:0], next_bit};
          cnt      <= cnt - 1'b1;
          if (cnt == '0)
          begin
            state <= DSF_DIV_DONE;
          end
        end
        DSF_DIV_DONE:
        begin
          // a zero denominator gives no frequency and flags the error
          freq_o    <= (den == '0) ? '0 : quot;
          div_err_o <= (den == '0);
          valid_o   <= 1'b1;
          state     <= DSF_DIV_IDLE;
        end
        default:
        begin
          state <= DSF_DIV_IDLE;
        end
      endcase
    end
  end

  // helper copy of the full scaled product for checking the quotient
  logic [PROD_W-1:0]       chk_prod;
  logic [`DSF_FIELD_W-1:0] chk_den;
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      chk_prod <= '0;
      chk_den  <= '0;
    end
    else if (start_i && state == DSF_DIV_IDLE)
    begin
      chk_prod <= PROD_W'((PROD_W'(cfg_i.base_frequency_value)
                  * PROD_W'(cfg_i.frequency_multiple_value)
                  * PROD_W'(cfg_i.fec_numerator)) << `DSF_SCALE_SHIFT);
      chk_den  <= cfg_i.fec_denominator;
    end
  end

  a_div_latency: assert property (@(posedge mclk_i) disable iff (rst_i)
    (start_i && state == DSF_DIV_IDLE) |=> !valid_o ##53 valid_o)
    else $error("frequency result not ready 54 cycles after start");

  a_quot_exact: assert property (@(posedge mclk_i) disable iff (rst_i)
    ($rose(valid_o) && chk_den != '0) |->
      ((68'(freq_o) * 68'(chk_den) <= 68'(chk_prod)) &&
       (68'(chk_prod) - 68'(freq_o) * 68'(chk_den) < 68'(chk_den))))
    else $error("frequency is not product times num over den");

endmodule

// File: hdl/dsf_cfg_regs.sv
// pll, phase acquisition and synthesizer frequency configuration bank
// Operation
// - two-bit code selects which digital plls run
// - bits 7:4 enable phase acquisition modules 0-3
// - base frequency field is unsigned hertz
// - frequency is base times multiple times sixteen
// - frequency scaled by numerator over denominator
// assumes byte-wide access from the serial host port, one access per cycle
`timescale 1ns/1ps
`include "dsf_consts.svh"

module dsf_cfg_regs
#(
  parameter int PROD_W = `DSF_PROD_W
)
(
  input  wire logic                    mclk_i,            // 20 MHz clock
  input  wire logic                    rst_i,             // async reset, high
  input  wire logic [`DSF_ADDR_W-1:0]  addr_i,            // register byte address
  input  wire logic                    wr_en_i,           // write strobe
  input  wire logic [`DSF_BYTE_W-1:0]  wdata_i,           // write byte
  input  wire logic                    rd_en_i,           // read strobe
  output logic [`DSF_BYTE_W-1:0]       rdata_o,           // read byte
  output logic                         first_digital_pll_en_o,  // first pll runs
  output logic                         second_digital_pll_en_o, // second pll runs
  output logic [3:0]                   phase_acq_en_o,    // phase modules on
  output dsf_pkg::dsf_synth_cfg_t      synth_a_cfg_o,     // synth a fields
  output logic [`DSF_FIELD_W-1:0]      synth_b_base_hz_o, // synth b base
  output logic [PROD_W-1:0]            synth_a_freq_hz_o, // synth a frequency
  output logic                         synth_a_valid_o,   // frequency current
  output logic                         synth_a_div_err_o  // zero denominator
);
  import dsf_pkg::*;

  localparam int IDX_W = $clog2(`DSF_NUM_BYTES);

  function automatic logic in_map(input logic [`DSF_ADDR_W-1:0] a);
    in_map = (a >= `DSF_OFS_REF3_LIM) && (a <= `DSF_OFS_LAST);
  endfunction

  function automatic logic [IDX_W-1:0] idx_of(input logic [`DSF_ADDR_W-1:0] a);
    logic [`DSF_ADDR_W-1:0] d;
    d      = a - `DSF_OFS_REF3_LIM;
    idx_of = d[IDX_W-1:0];
  endfunction

  // reset byte for each index, most significant byte at the lower address
  function automatic logic [`DSF_BYTE_W-1:0] rst_byte(input int i);
    logic [`DSF_FIELD_W-1:0] a_base;
    logic [`DSF_FIELD_W-1:0] a_mult;
    logic [31:0]             a_ratio;
    logic [`DSF_FIELD_W-1:0] b_base;
    a_base  = `DSF_RST_A_BASE;
    a_mult  = `DSF_RST_A_MULT;
    a_ratio = `DSF_RST_A_RATIO;
    b_base  = `DSF_RST_B_BASE;
    case (i)
      0:       rst_byte = `DSF_RST_REF3_LIM;
      1:       rst_byte = `DSF_RST_PLL_CFG;
      2:       rst_byte = a_base[15:8];
      3:       rst_byte = a_base[7:0];
      4:       rst_byte = a_mult[15:8];
      5:       rst_byte = a_mult[7:0];
      6:       rst_byte = a_ratio[31:24];
      7:       rst_byte = a_ratio[23:16];
      8:       rst_byte = a_ratio[15:8];
      9:       rst_byte = a_ratio[7:0];
      10:      rst_byte = b_base[15:8];
      11:      rst_byte = b_base[7:0];
      default: rst_byte = '0;
    endcase
  endfunction

  localparam logic [IDX_W-1:0] IDX_PLL    = IDX_W'(`DSF_OFS_PLL_CFG - `DSF_OFS_REF3_LIM);
  localparam logic [IDX_W-1:0] IDX_A_FRST = IDX_W'(`DSF_OFS_A_BASE - `DSF_OFS_REF3_LIM);
  localparam logic [IDX_W-1:0] IDX_A_LAST = IDX_W'(`DSF_OFS_B_BASE - `DSF_OFS_REF3_LIM - 1);

  logic [`DSF_BYTE_W-1:0] regs [0:`DSF_NUM_BYTES-1];
  logic                   wr_hit;
  logic                   a_hit;
  logic                   recalc_pend;
  logic                   calc_start;
  logic                   calc_idle;
  logic                   calc_run;
  dsf_pll_sel_t           pll_sel;
  dsf_synth_cfg_t         a_cfg;
  logic [`DSF_FIELD_W-1:0] b_base;

  assign wr_hit = wr_en_i && in_map(addr_i);
  assign a_hit  = wr_hit && (idx_of(addr_i) >= IDX_A_FRST) && (idx_of(addr_i) <= IDX_A_LAST);

  // byte storage; every byte holds what was last written
  genvar g;
  generate
    for (g = 0; g < `DSF_NUM_BYTES; g++)
    begin : g_byte
      // reset value fixed at elaboration so the reset branch loads a constant
      localparam logic [`DSF_BYTE_W-1:0] RST_VAL = rst_byte(g);
      always_ff @(posedge mclk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          regs[g] <= RST_VAL;
        end
        else if (wr_hit && idx_of(addr_i) == IDX_W'(g))
        begin
          regs[g] <= wdata_i;
        end
      end
    end
  endgenerate

  // field assembly, lower address is the high byte
  always_comb
  begin
    pll_sel                        = dsf_pll_sel_t'(regs[IDX_PLL][`DSF_PLL_SEL_MSB:`DSF_PLL_SEL_LSB]);
    a_cfg.base_frequency_value     = {regs[2], regs[3]};
    a_cfg.frequency_multiple_value = {regs[4], regs[5]};
    a_cfg.fec_numerator            = {regs[6], regs[7]};
    a_cfg.fec_denominator          = {regs[8], regs[9]};
    b_base                         = {regs[10], regs[11]};
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= '0;
    end
    else if (rd_en_i)
    begin
      rdata_o <= in_map(addr_i) ? regs[idx_of(addr_i)] : '0;
    end
  end

  // pll run enables; the reserved code keeps both stopped
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      first_digital_pll_en_o  <= 1'b0;
      second_digital_pll_en_o <= 1'b0;
    end
    else
    begin
      case (pll_sel)
        DSF_PLL_FIRST:
        begin
          first_digital_pll_en_o  <= 1'b1;
          second_digital_pll_en_o <= 1'b0;
        end
        DSF_PLL_BOTH:
        begin
          first_digital_pll_en_o  <= 1'b1;
          second_digital_pll_en_o <= 1'b1;
        end
        default:
        begin
          first_digital_pll_en_o  <= 1'b0;
          second_digital_pll_en_o <= 1'b0;
        end
      endcase
    end
  end

  // phase acquisition power control, one bit per module
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_acq_en_o <= '0;
    end
    else
    begin
      phase_acq_en_o <= regs[IDX_PLL][`DSF_PHASE_EN_MSB:`DSF_PHASE_EN_LSB];
    end
  end

  // field outputs for the synthesizers
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      synth_a_cfg_o     <= '0;
      synth_b_base_hz_o <= '0;
    end
    else
    begin
      synth_a_cfg_o     <= a_cfg;
      synth_b_base_hz_o <= b_base;
    end
  end

  // recompute after reset and after any synth a write; a write during
  // a running calculation is kept pending, so the set wins over the clear
  assign calc_idle = !calc_start && !calc_run;

  // a calculation runs from its start pulse until its result shows valid
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      calc_run <= 1'b0;
    end
    else if (calc_start)
    begin
      calc_run <= 1'b1;
    end
    else if (synth_a_valid_o)
    begin
      calc_run <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      recalc_pend <= 1'b1;
      calc_start  <= 1'b0;
    end
    else
    begin
      calc_start  <= recalc_pend && calc_idle && !a_hit;
      recalc_pend <= a_hit || (recalc_pend && !(calc_idle && !a_hit));
    end
  end

  dsf_freq_calc
  #(
    .PROD_W (PROD_W)
  )
  u_calc
  (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .start_i   (calc_start),
    .cfg_i     (a_cfg),
    .freq_o    (synth_a_freq_hz_o),
    .valid_o   (synth_a_valid_o),
    .div_err_o (synth_a_div_err_o)
  );

  a_pll_both: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pll_sel == DSF_PLL_BOTH) |=> (first_digital_pll_en_o && second_digital_pll_en_o))
    else $error("code 10 did not run both plls");

  a_pll_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pll_sel == DSF_PLL_NONE || pll_sel == DSF_PLL_RSVD) |=>
      !(first_digital_pll_en_o || second_digital_pll_en_o))
    else $error("plls running with code 00 or 11");

  a_phase_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_hit && idx_of(addr_i) == IDX_PLL) |=> ##1 (phase_acq_en_o == $past(wdata_i[7:4], 2)))
    else $error("phase enables differ from bits 7:4");

  a_base_order: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_en_i && addr_i == `DSF_OFS_B_BASE) |=> ##1 (synth_b_base_hz_o[15:8] == $past(wdata_i, 2)))
    else $error("base high byte not at lower address");

  a_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_hit ##1 (rd_en_i && !wr_en_i && addr_i == $past(addr_i))) |=>
      (rdata_o == $past(wdata_i, 2)))
    else $error("read did not return last written byte");

  a_recalc_once: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((a_hit && calc_idle) ##1 !a_hit) |=> calc_start)
    else $error("synth a write did not restart calculation");

endmodule

// File: dv/dsf_cfg_regs_tb_top.sv
// self-checking bench for the pll and synthesizer configuration bank
// assumes dsf_pkg is compiled first and dsf_consts.svh is on the include path
`timescale 1ns/1ps
`include "dsf_consts.svh"

module dsf_cfg_regs_tb_top;
  import dsf_pkg::*;

  logic                   mclk_i;
  logic                   rst_i;
  logic [7:0]             addr_i;
  logic                   wr_en_i;
  logic [7:0]             wdata_i;
  logic                   rd_en_i;
  logic [7:0]             rdata_o;
  logic                   pll_a_en;
  logic                   pll_b_en;
  logic [3:0]             phase_en;
  dsf_synth_cfg_t         cfg_a;
  logic [15:0]            base_b;
  logic [`DSF_PROD_W-1:0] freq_a;
  logic                   valid_a;
  logic                   err_a;
  int                     failures;
  int                     compares;

  dsf_cfg_regs dut_u
  (
    .mclk_i                  (mclk_i),
    .rst_i                   (rst_i),
    .addr_i                  (addr_i),
    .wr_en_i                 (wr_en_i),
    .wdata_i                 (wdata_i),
    .rd_en_i                 (rd_en_i),
    .rdata_o                 (rdata_o),
    .first_digital_pll_en_o  (pll_a_en),
    .second_digital_pll_en_o (pll_b_en),
    .phase_acq_en_o          (phase_en),
    .synth_a_cfg_o           (cfg_a),
    .synth_b_base_hz_o       (base_b),
    .synth_a_freq_hz_o       (freq_a),
    .synth_a_valid_o         (valid_a),
    .synth_a_div_err_o       (err_a)
  );

  always #25 mclk_i = ~mclk_i;

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_en_i <= 1'b1;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask

  // settle after a write, then look at the field outputs
  task automatic settle();
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  // wait until the result stays valid; a stale result shows for at most 3 cycles
  task automatic wait_valid();
    int n;
    int run;
    run = 0;
    repeat (3) @(posedge mclk_i);
    for (n = 0; n < 400 && run < 6; n++)
    begin
      @(negedge mclk_i);
      run = (valid_a === 1'b1) ? run + 1 : 0;
    end
    chk("valid_a steady", {63'h0, run >= 6}, 64'h1);
  endtask

  task automatic t_reset_defaults();
    logic [7:0] dflt [12] = '{8'h55, 8'hf2, 8'h9c, 8'h40, 8'h07, 8'h98,
                              8'h00, 8'h01, 8'h00, 8'h01, 8'h61, 8'ha8};
    logic [7:0] d;
    settle();
    chk("pll_a_en", {63'h0, pll_a_en}, 64'h1);
    chk("pll_b_en", {63'h0, pll_b_en}, 64'h1);
    chk("phase_en", {60'h0, phase_en}, 64'hf);
    chk("cfg_a", cfg_a, 64'h9c40_0798_0001_0001);
    chk("base_b", {48'h0, base_b}, 64'h61a8);
    for (int i = 0; i < 12; i++)
    begin
      rd(8'h4e + 8'(i), d);
      chk("reset byte", {56'h0, d}, {56'h0, dflt[i]});
    end
    wait_valid();
    // 40000 x 1944 x 16 x 1 / 1
    chk("freq default", {12'h0, freq_a}, 64'd1244160000);
  endtask

  task automatic t_pll_codes();
    logic [7:0] v;
    logic [7:0] d;
    for (int i = 0; i < 4; i++)
    begin
      v = {4'h1 << i, 2'(i), 2'(i)};
      wr(8'h4f, v);
      settle();
      chk("pll_a_en", {63'h0, pll_a_en}, 64'(i == 1 || i == 2));
      chk("pll_b_en", {63'h0, pll_b_en}, 64'(i == 2));
      chk("phase_en", {60'h0, phase_en}, 64'(4'h1 << i));
      rd(8'h4f, d);
      chk("pll byte", {56'h0, d}, {56'h0, v});
    end
  endtask

  task automatic t_fec_ratio();
    logic [7:0] bytes [8] = '{8'h61, 8'ha8, 8'h0c, 8'h35, 8'h00, 8'h42, 8'h00, 8'h40};
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
      wr(8'h50 + 8'(i), bytes[i]);
    settle();
    chk("cfg_a", cfg_a, 64'h61a8_0c35_0042_0040);
    rd(8'h55, d);
    chk("numerator lo", {56'h0, d}, 64'h42);
    wait_valid();
    // 25000 x 3125 x 16 x 66 / 64
    chk("freq fec", {12'h0, freq_a}, 64'd1289062500);
    chk("div_err", {63'h0, err_a}, 64'h0);
    wr(8'h57, 8'h00);
    wait_valid();
    chk("freq zero den", {12'h0, freq_a}, 64'h0);
    chk("div_err", {63'h0, err_a}, 64'h1);
    wr(8'h50, 8'h1f);
    wr(8'h51, 8'h40);
    wr(8'h55, 8'h01);
    wr(8'h57, 8'h01);
    wait_valid();
    // 8000 x 3125 x 16 x 1 / 1
    chk("freq 8k", {12'h0, freq_a}, 64'd400000000);
    chk("div_err", {63'h0, err_a}, 64'h0);
  endtask

  task automatic t_map_edges();
    logic [7:0] d;
    wr(8'h4d, 8'haa);
    wr(8'h5a, 8'h33);
    wr(8'h58, 8'h9c);
    wr(8'h59, 8'h40);
    settle();
    chk("base_b", {48'h0, base_b}, 64'h9c40);
    rd(8'h4d, d);
    chk("unmapped lo", {56'h0, d}, 64'h0);
    rd(8'h5a, d);
    chk("unmapped hi", {56'h0, d}, 64'h0);
    rd(8'h4e, d);
    chk("limits byte", {56'h0, d}, 64'h55);
    rd(8'h58, d);
    chk("base_b hi", {56'h0, d}, 64'h9c);
    // write followed at once by a read of the same byte
    @(posedge mclk_i);
    addr_i  <= 8'h4e;
    wdata_i <= 8'h3c;
    wr_en_i <= 1'b1;
    @(posedge mclk_i);
    wr_en_i <= 1'b0;
    rd_en_i <= 1'b1;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    @(negedge mclk_i);
    chk("write then read", {56'h0, rdata_o}, 64'h3c);
  endtask

  // reset in mid-run brings back the defaults and a fresh result
  task automatic t_reset_again();
    logic [7:0] d;
    wr(8'h4f, 8'h01);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    settle();
    chk("pll_b_en reset", {63'h0, pll_b_en}, 64'h1);
    chk("phase_en reset", {60'h0, phase_en}, 64'hf);
    rd(8'h4e, d);
    chk("limits reset", {56'h0, d}, 64'h55);
    wait_valid();
    chk("freq reset", {12'h0, freq_a}, 64'd1244160000);
  endtask

  initial
  begin
    mclk_i   = 1'b0;
    rst_i    = 1'b1;
    addr_i   = 8'h00;
    wr_en_i  = 1'b0;
    wdata_i  = 8'h00;
    rd_en_i  = 1'b0;
    failures = 0;
    compares = 0;
    repeat (20) @(posedge mclk_i);
    rst_i <= 1'b0;
    t_reset_defaults();
    t_pll_codes();
    t_fec_ratio();
    t_map_edges();
    t_reset_again();
    close_out();
  end

  // bench needs about 500 cycles; cut a hang well beyond that
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    close_out();
  end
endmodule
